// ---- csl_pkg.sv ----
/*
 * Shared constants for the credit stream link: default widths, credit capacity,
 * buffer depth and reset values used by both ends.
 * Assumes both ends run on one common clock with one common active-low reset.
 */
`default_nettype none

package csl_pkg;

    // ************************************************************
    // Link widths
    // ************************************************************
    localparam int DATA_W_DEF     = 32;
    localparam int DATA_W_MAX     = 16368;
    localparam int ERR_W_DEF      = 2;
    localparam int ERR_W_MAX      = 256;
    localparam int CREDIT_W_MAX   = 9;

    // ************************************************************
    // Credit capacity and buffering
    // ************************************************************
    localparam int MAX_CREDIT_DEF = 8;
    localparam int CREDIT_W_DEF   = $clog2(MAX_CREDIT_DEF + 1);
    localparam int FIFO_DEPTH_DEF = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic VALID_RST    = 1'b0;
    localparam logic UPDATE_RST   = 1'b0;
    localparam logic RETURN_RST   = 1'b0;

    typedef enum logic [1:0] {
        CSL_SK_INIT = 2'b00,
        CSL_SK_RUN  = 2'b01
    } csl_sink_state_t;

endpackage

`default_nettype wire

// ---- csl_if.sv ----
/*
 * Carrier between the two ends of the credit stream link.
 * Assumes the testbench instantiates it once and ties each end to its modport.
 */
`timescale 1ns/1ps
`default_nettype none

interface csl_if #(
    parameter int DATA_W   = csl_pkg::DATA_W_DEF,
    parameter int ERR_W    = csl_pkg::ERR_W_DEF,
    parameter int CREDIT_W = csl_pkg::CREDIT_W_DEF
);
    logic                update;
    logic [CREDIT_W-1:0] credit;
    logic                returnCredit;
    logic [DATA_W-1:0]   data;
    logic                valid;
    logic [ERR_W-1:0]    error;

    modport source (
        input  update,
        input  credit,
        output returnCredit,
        output data,
        output valid,
        output error
    );

    modport sink (
        output update,
        output credit,
        input  returnCredit,
        input  data,
        input  valid,
        input  error
    );
endinterface

`default_nettype wire

// ---- csl_source.sv ----
/*
 * Source end of the credit stream link, with its staging FIFO.
 * Holds csl_fifo (generic flop FIFO, also used by the sink) and csl_source.
 * Assumes one shared clock, asynchronous active-low reset and a sink that only
 * grants credits it can really honour.
 */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Generic FIFO
// ************************************************************
module csl_fifo #(
    parameter int WIDTH = csl_pkg::DATA_W_DEF,
    parameter int DEPTH = csl_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             wrValid,
    output logic                  wrReady,
    input  wire logic [WIDTH-1:0] wrData,
    output logic                  rdValid,
    input  wire logic             rdReady,
    output logic      [WIDTH-1:0] rdData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("csl_fifo needs DEPTH of at least 2 and WIDTH of at least 1.");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] wrPtr_d;
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W-1:0] rdPtr_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             hasRoom_q;
    logic             hasData_q;
    wire              push;
    wire              pop;
    wire              wrLast;
    wire              rdLast;

    assign push    = wrValid & hasRoom_q;
    assign pop     = rdReady & hasData_q;
    assign wrLast  = (wrPtr_q == PTR_W'(DEPTH - 1));
    assign rdLast  = (rdPtr_q == PTR_W'(DEPTH - 1));
    assign wrPtr_d = push ? (wrLast ? '0 : wrPtr_q + PTR_W'(1)) : wrPtr_q;
    assign rdPtr_d = pop ? (rdLast ? '0 : rdPtr_q + PTR_W'(1)) : rdPtr_q;
    assign count_d = count_q + CNT_W'(push) - CNT_W'(pop);
    // Both handshake flags live in flops, so ready and valid leave straight from a register.
    assign wrReady = hasRoom_q;
    assign rdValid = hasData_q;
    assign rdData  = mem[rdPtr_q];

    // Entries are not reset; the data flag keeps stale words from being read.
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (push && wrPtr_q == PTR_W'(i)) begin
                mem[i] <= wrData;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            hasRoom_q <= 1'b1;
            hasData_q <= 1'b0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            hasRoom_q <= (count_d != CNT_W'(DEPTH));
            hasData_q <= (count_d != '0);
        end
    end
endmodule

// ************************************************************
// Source end
// ************************************************************
module csl_source #(
    parameter int DATA_W     = csl_pkg::DATA_W_DEF,
    parameter int ERR_W      = csl_pkg::ERR_W_DEF,
    parameter int CREDIT_W   = csl_pkg::CREDIT_W_DEF,
    parameter int FIFO_DEPTH = csl_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    csl_if.source                  link,
    input  wire logic              inValid,
    output logic                   inReady,
    input  wire logic [DATA_W-1:0] inData,
    input  wire logic [ERR_W-1:0]  inError,
    input  wire logic              giveBackReq,
    output logic                   giveBackAck,
    output logic [CREDIT_W:0]      creditLevel
);
    // One spare bit so that back-to-back grants cannot wrap the counter.
    localparam int CNT_W  = CREDIT_W + 1;
    localparam int WORD_W = DATA_W + ERR_W;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (DATA_W < 1 || DATA_W > csl_pkg::DATA_W_MAX) begin : g_bad_data
            $error("csl_source DATA_W out of range.");
        end
        if (ERR_W < 1 || ERR_W > csl_pkg::ERR_W_MAX) begin : g_bad_err
            $error("csl_source ERR_W out of range.");
        end
        if (CREDIT_W < 1 || CREDIT_W > csl_pkg::CREDIT_W_MAX) begin : g_bad_cred
            $error("csl_source CREDIT_W out of range.");
        end
    endgenerate

    // ************************************************************
    // Staging buffer
    // ************************************************************
    logic [WORD_W-1:0] stageData;
    logic              stageValid;
    wire               send;

    // The user side stalls on inReady once eight beats wait for credit.
    csl_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_stage (
        .clk     (clk),
        .rst_b   (rst_b),
        .wrValid (inValid),
        .wrReady (inReady),
        .wrData  ({inError, inData}),
        .rdValid (stageValid),
        .rdReady (send),
        .rdData  (stageData)
    );

    // ************************************************************
    // Credit accounting
    // ************************************************************
    logic [CNT_W-1:0] credit_q;
    logic [CNT_W-1:0] credit_d;
    wire              haveCredit;
    wire              giveBack;
    wire  [CNT_W-1:0] grant;
    wire  [CNT_W-1:0] spent;

    assign haveCredit = (credit_q != '0);
    assign send       = stageValid & haveCredit;
    // Data takes precedence; a give-back waits for a cycle with no beat.
    assign giveBack   = giveBackReq & haveCredit & ~send;
    assign grant      = link.update ? CNT_W'(link.credit) : '0;
    assign spent      = CNT_W'(send) + CNT_W'(giveBack);
    assign credit_d   = credit_q + grant - spent;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            credit_q <= '0;
        end else begin
            credit_q <= credit_d;
        end
    end

    // ************************************************************
    // Registered link outputs
    // ************************************************************
    logic              valid_q;
    logic              ret_q;
    logic [DATA_W-1:0] data_q;
    logic [ERR_W-1:0]  err_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_q <= csl_pkg::VALID_RST;
            ret_q   <= csl_pkg::RETURN_RST;
            data_q  <= '0;
            err_q   <= '0;
        end else begin
            valid_q <= send;
            ret_q   <= giveBack;
            if (send) begin
                data_q <= stageData[DATA_W-1:0];
                err_q  <= stageData[WORD_W-1:DATA_W];
            end
        end
    end

    logic [CNT_W-1:0] level_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= '0;
        end else begin
            level_q <= credit_d;
        end
    end

    assign link.valid        = valid_q;
    assign link.returnCredit = ret_q;
    assign link.data         = data_q;
    assign link.error        = err_q;
    assign giveBackAck       = ret_q;
    assign creditLevel       = level_q;
endmodule

`default_nettype wire

// ---- csl_sink.sv ----
/*
 * Sink end of the credit stream link: receive buffer and credit grants.
 * Assumes csl_fifo from csl_source.sv is compiled first and that the source
 * never sends more beats than it was granted.
 */
`timescale 1ns/1ps
`default_nettype none

module csl_sink #(
    parameter int DATA_W     = csl_pkg::DATA_W_DEF,
    parameter int ERR_W      = csl_pkg::ERR_W_DEF,
    parameter int CREDIT_W   = csl_pkg::CREDIT_W_DEF,
    parameter int MAX_CREDIT = csl_pkg::MAX_CREDIT_DEF,
    parameter int FIFO_DEPTH = csl_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    csl_if.sink                    link,
    output logic                   outValid,
    input  wire logic              outReady,
    output logic      [DATA_W-1:0] outData,
    output logic      [ERR_W-1:0]  outError,
    output logic                   overflow
);
    localparam int WORD_W = DATA_W + ERR_W;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (MAX_CREDIT < 1 || CREDIT_W != $clog2(MAX_CREDIT + 1)
                || CREDIT_W > csl_pkg::CREDIT_W_MAX) begin : g_bad_cred
            $error("csl_sink CREDIT_W must match MAX_CREDIT and stay in range.");
        end
        if (DATA_W < 1 || DATA_W > csl_pkg::DATA_W_MAX) begin : g_bad_data
            $error("csl_sink DATA_W out of range.");
        end
        if (ERR_W < 1 || ERR_W > csl_pkg::ERR_W_MAX) begin : g_bad_err
            $error("csl_sink ERR_W out of range.");
        end
        if (FIFO_DEPTH < MAX_CREDIT) begin : g_bad_depth
            $error("csl_sink buffer smaller than its credit capacity.");
        end
    endgenerate

    // ************************************************************
    // Receive buffer
    // ************************************************************
    logic [WORD_W-1:0] rxWord;
    logic              rxReady;
    wire               popped;

    csl_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx (
        .clk     (clk),
        .rst_b   (rst_b),
        .wrValid (link.valid),
        .wrReady (rxReady),
        .wrData  ({link.error, link.data}),
        .rdValid (outValid),
        .rdReady (outReady),
        .rdData  (rxWord)
    );

    assign popped   = outValid & outReady;
    assign outData  = rxWord[DATA_W-1:0];
    assign outError = rxWord[WORD_W-1:DATA_W];

    // ************************************************************
    // Credit grants
    // ************************************************************
    csl_pkg::csl_sink_state_t state_q;
    csl_pkg::csl_sink_state_t state_d;
    logic                     update_q;
    logic                     update_d;
    logic [CREDIT_W-1:0]      credit_q;
    logic [CREDIT_W-1:0]      credit_d;
    logic                     over_q;
    wire  [CREDIT_W-1:0]      freed;

    // A returned credit is re-advertised on the next cycle, alongside any popped slot.
    assign freed = CREDIT_W'(popped) + CREDIT_W'(link.returnCredit);

    always_comb begin
        state_d  = state_q;
        update_d = 1'b0;
        credit_d = '0;
        case (state_q)
            csl_pkg::CSL_SK_INIT: begin
                update_d = 1'b1;
                credit_d = CREDIT_W'(MAX_CREDIT);
                state_d  = csl_pkg::CSL_SK_RUN;
            end
            csl_pkg::CSL_SK_RUN: begin
                update_d = (freed != '0);
                credit_d = freed;
            end
            default: begin
                state_d = csl_pkg::CSL_SK_INIT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= csl_pkg::CSL_SK_INIT;
            update_q <= csl_pkg::UPDATE_RST;
            credit_q <= '0;
            over_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            update_q <= update_d;
            credit_q <= credit_d;
            // Sticky: a beat that arrives while the receive buffer is full is lost and flagged.
            over_q   <= over_q | (link.valid & ~rxReady);
        end
    end

    assign link.update = update_q;
    assign link.credit = credit_q;
    assign overflow    = over_q;
endmodule

`default_nettype wire

// ---- csl_link_chk.sv ----
/*
 * Concurrent checks on the wires between the two ends of the credit stream link.
 * Assumes one clock, an active-low asynchronous reset and the carrier's signals.
 */
`timescale 1ns/1ps
`default_nettype none

module csl_link_chk #(
    parameter int DATA_W   = 32,
    parameter int ERR_W    = 2,
    parameter int CREDIT_W = 4,
    parameter int CAP      = 8
) (
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic                update,
    input wire logic [CREDIT_W-1:0] credit,
    input wire logic                returnCredit,
    input wire logic [DATA_W-1:0]   data,
    input wire logic                valid,
    input wire logic [ERR_W-1:0]    error
);
    // ************************************************************
    // Credit model seen from the wires
    // ************************************************************
    // Beats and give-backs are counted one edge late, when they reach the wires, so
    // the model never drops below the source's real figure and the valid check is safe.
    logic [CREDIT_W:0] availCount_q;
    logic [CREDIT_W:0] availCount_d;
    logic [CREDIT_W:0] grantAdd;

    assign grantAdd     = update ? (CREDIT_W+1)'(credit) : '0;
    assign availCount_d = availCount_q + grantAdd - (CREDIT_W+1)'(valid)
                          - (CREDIT_W+1)'(returnCredit);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            availCount_q <= '0;
        end else begin
            availCount_q <= availCount_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_initGrant;
        update && credit == CREDIT_W'(CAP);
    endsequence
    sequence s_giveBack;
        returnCredit;
    endsequence
    sequence s_regrant;
        update && credit != '0;
    endsequence

    valid_credit_a: assert property (valid |-> availCount_q != '0)
        else $error("beat sent without credit");
    credit_bound_a: assert property (availCount_q <= (CREDIT_W+1)'(CAP))
        else $error("more credit granted than the sink can hold");
    credit_idle_a: assert property (!update |-> credit == '0)
        else $error("credit bus not idle outside a grant");
    init_grant_a: assert property ($rose(rst_b) |=> s_initGrant)
        else $error("no full grant after reset");
    no_early_a: assert property ($rose(rst_b) |-> !valid [*2])
        else $error("beat before any grant");
    regrant_a: assert property (s_giveBack |=> s_regrant)
        else $error("returned credit not advertised again");
    beat_first_a: assert property (returnCredit |-> !valid)
        else $error("give-back in a beat cycle");
    data_hold_a: assert property (!valid |-> $stable(data) && $stable(error))
        else $error("payload moved without a beat");
endmodule

`default_nettype wire

// ---- credit_stream_link_tb.sv ----
/*
 * Self-checking bench for the credit stream link: both ends face each other.
 * Assumes the package, carrier, both ends and the checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module credit_stream_link_tb;
    localparam int DW  = 32;
    localparam int EW  = 2;
    localparam int CW  = csl_pkg::CREDIT_W_DEF;
    localparam int CAP = csl_pkg::MAX_CREDIT_DEF;
    localparam int TOP = 3000;

    logic             clk;
    logic             rst_b;
    logic             inValid;
    logic             inReady;
    logic [DW-1:0]    inData;
    logic [EW-1:0]    inError;
    logic             giveBackReq;
    logic             giveBackAck;
    logic [CW:0]      creditLevel;
    logic             outValid;
    logic             outReady;
    logic [DW-1:0]    outData;
    logic [EW-1:0]    outError;
    logic             overflow;
    logic [EW+DW-1:0] expQ[$];
    logic [EW+DW-1:0] gotQ[$];
    int               fail_count = 0;
    int               checks = 0;
    int               cycles = 0;
    int               ackCount = 0;

    csl_if #(.DATA_W(DW), .ERR_W(EW), .CREDIT_W(CW)) u_csl_if ();

    csl_source #(.DATA_W(DW), .ERR_W(EW), .CREDIT_W(CW)) u_csl_source (
        .clk(clk), .rst_b(rst_b), .link(u_csl_if.source), .inValid(inValid),
        .inReady(inReady), .inData(inData), .inError(inError),
        .giveBackReq(giveBackReq), .giveBackAck(giveBackAck), .creditLevel(creditLevel));

    csl_sink #(.DATA_W(DW), .ERR_W(EW), .CREDIT_W(CW)) u_csl_sink (
        .clk(clk), .rst_b(rst_b), .link(u_csl_if.sink), .outValid(outValid),
        .outReady(outReady), .outData(outData), .outError(outError), .overflow(overflow));

    csl_link_chk #(.DATA_W(DW), .ERR_W(EW), .CREDIT_W(CW), .CAP(CAP)) u_csl_link_chk (
        .clk(clk), .rst_b(rst_b), .update(u_csl_if.update), .credit(u_csl_if.credit),
        .returnCredit(u_csl_if.returnCredit), .data(u_csl_if.data),
        .valid(u_csl_if.valid), .error(u_csl_if.error));

    // ************************************************************
    // Clock, watchdog and monitors
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (rst_b === 1'b1 && outValid === 1'b1 && outReady === 1'b1) begin
            gotQ.push_back({outError, outData});
        end
        if (giveBackAck === 1'b1) begin
            ackCount++;
        end
        if (cycles == TOP) begin
            fail_count++;
            $display("timeout at %0t", $time);
            finish_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        step(4);
        `CHK(creditLevel, (CW+1)'(CAP))
        `CHK(u_csl_if.valid, 1'b0)
        `CHK(outValid, 1'b0)
        $display("test reset done");
    endtask

    // The sink holds its pops, so the source must stop at its grant and the
    // staging buffer fills behind it until it refuses.
    task automatic t_fill();
        int n;
        int k;
        int a0;
        logic [EW+DW-1:0] g;
        logic [EW+DW-1:0] e;
        n = 0;
        inValid = 1'b1;
        inData = 32'hC0DE_0000;
        inError = 2'h0;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (inReady === 1'b1) begin
                expQ.push_back({inError, inData});
                n++;
            end
            #1;
            inData = 32'hC0DE_0000 + DW'(n);
            inError = EW'(n);
        end
        inValid = 1'b0;
        `CHK(n, CAP + csl_pkg::FIFO_DEPTH_DEF)
        `CHK(creditLevel, (CW+1)'(0))
        `CHK(overflow, 1'b0)
        a0 = ackCount;
        giveBackReq = 1'b1;
        step(3);
        giveBackReq = 1'b0;
        step(2);
        `CHK(ackCount - a0, 0)
        outReady = 1'b1;
        for (k = 0; k < 200 && gotQ.size() < n; k++) @(posedge clk);
        step(6);
        `CHK(gotQ.size(), n)
        while (gotQ.size() > 0 && expQ.size() > 0) begin
            g = gotQ.pop_front();
            e = expQ.pop_front();
            `CHK(g, e)
        end
        `CHK(creditLevel, (CW+1)'(CAP))
        `CHK(overflow, 1'b0)
        $display("test fill done");
    endtask

    task automatic t_giveback();
        int a0;
        logic [EW+DW-1:0] g;
        a0 = ackCount;
        giveBackReq = 1'b1;
        step(3);
        giveBackReq = 1'b0;
        step(6);
        `CHK(ackCount - a0, 3)
        `CHK(creditLevel, (CW+1)'(CAP))
        // A staged beat takes the cycle of one give-back, so three held cycles return two.
        a0 = ackCount;
        giveBackReq = 1'b1;
        inValid = 1'b1;
        inData = 32'hBEEF_0001;
        inError = 2'h3;
        step(1);
        inValid = 1'b0;
        step(2);
        giveBackReq = 1'b0;
        step(8);
        `CHK(ackCount - a0, 2)
        `CHK(gotQ.size(), 1)
        g = gotQ.pop_front();
        `CHK(g, {2'h3, 32'hBEEF_0001})
        `CHK(creditLevel, (CW+1)'(CAP))
        $display("test giveback done");
    endtask

    task automatic finish_test();
        $display("counts: checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        inValid = 1'b0;
        inData = '0;
        inError = '0;
        giveBackReq = 1'b0;
        outReady = 1'b0;
        t_reset();
        t_fill();
        t_giveback();
        finish_test();
    end
endmodule

`default_nettype wire
